// ===== scd_pkg.sv
// Purpose: constants and types for the strap configuration decoder
// Assumes: switch contacts read 0 when ON, 1 when OFF
// Notes:   registers sit on APB at word offsets below
// How it works
// - switch ON reads 0, OFF reads 1
// - clock strap 0 common, 1 split upstream
// - mode 01 adapter, 10 dual host, 11 transparent
// - root port codes 0..4, rest reserved
// - isolated port same encoding, used by mode
// - lane config codes decode to widths
// - hotplug select 1 hands slot to controller
// - latch sense 0 closed, 1 open
// - bypass 0 loop on, 1 plain fanout
// - bandwidth 0 is 500 kHz, 1 is 1 MHz
// - three bits form address 70h..77h
// - spare contact is plain general input
package scd_pkg;
    // ==========================================================
    // register map
    localparam logic [11:0] SCD_RAW_OFS    = 12'h000;
    localparam logic [11:0] SCD_DECODE_OFS = 12'h004;
    localparam logic [11:0] SCD_LANES_OFS  = 12'h008;
    localparam logic [11:0] SCD_CTRL_OFS   = 12'h00C;
    // ==========================================================
    // values after reset (documented switch defaults), then port limit, address base and mode codes
    localparam logic [1:0] SCD_MODE_RST   = 2'h3;
    localparam logic [3:0] SCD_ROOT_RST   = 4'h0;
    localparam logic [3:0] SCD_ISO_RST    = 4'h1;
    localparam logic [3:0] SCD_LANE_RST   = 4'h8;
    localparam logic [2:0] SCD_ADDR_RST   = 3'h7;
    localparam logic [3:0] SCD_PORT_MAX   = 4'h4;
    localparam logic [6:0] SCD_ADDR_BASE  = 7'h70;
    localparam logic [1:0] SCD_MODE_RSVD  = 2'h0;
    localparam logic [1:0] SCD_MODE_ADAPT = 2'h1;
    localparam logic [1:0] SCD_MODE_DUAL  = 2'h2;
    // ==========================================================
    // field positions in the raw strap word
    localparam int SCD_SPARE_POS = 22;
    localparam int SCD_SPLIT_POS = 21;
    localparam int SCD_MODE_POS  = 19;
    localparam int SCD_ROOT_POS  = 15;
    localparam int SCD_ISO_POS   = 11;
    localparam int SCD_LANE_POS  = 7;
    localparam int SCD_HP_POS    = 6;
    localparam int SCD_LATCH_POS = 5;
    localparam int SCD_BYP_POS   = 4;
    localparam int SCD_BW_POS    = 3;
    localparam int SCD_ADDR_POS  = 0;
    // lane width codes per port: 0 none, 1 x1, 2 x2, 3 x4
    typedef logic [9:0] scd_lanes_t;
    typedef struct packed {
        logic       spare;
        logic       split_clock_domain_strap;
        logic [1:0] operating_mode_strap;
        logic [3:0] root_facing_port_strap;
        logic [3:0] isolated_port_strap;
        logic [3:0] lane_width_config_strap;
        logic       slot_hotplug_select;
        logic       retention_latch_sense_n;
        logic       pll_bypass;
        logic       loop_bandwidth_select;
        logic [2:0] addr_low;
    } scd_straps_t;
    typedef enum logic [1:0] {
        SCD_WAIT = 2'b01,
        SCD_HELD = 2'b10
    } scd_state_t;
endpackage

// ===== scd_decoder.sv
// Purpose: capture board straps once after reset and decode them
// Assumes: strap pins are asynchronous to pclk
// Notes:   values stay frozen until the next reset or a software re-capture through the control register
`timescale 1ns/1ps
module scd_decoder
    import scd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire scd_straps_t strap_pins,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             split_clock_domain,
    output logic       [1:0] operating_mode,
    output logic             non_transparent,
    output logic       [2:0] root_facing_port,
    output logic       [2:0] isolated_port,
    output logic             isolated_port_valid,
    output scd_lanes_t       lane_widths,
    output logic             slot_hotplug_enable,
    output logic             retention_latch_open,
    output logic             pll_bypass,
    output logic             loop_bw_1mhz,
    output logic       [6:0] mgmt_slave_addr,
    output logic             spare_input,
    output logic             config_error,
    output logic             straps_valid
);
    // ==========================================================
    // synchroniser: first stage read only by second stage
    scd_straps_t sync1_reg;
    scd_straps_t sync2_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= strap_pins;
            sync2_reg <= sync1_reg;
        end
    end

    // ==========================================================
    // capture state: wait two edges for the synchroniser to fill
    scd_state_t  state_reg;
    scd_state_t  state_next;
    logic  [1:0] fill_reg;
    logic  [1:0] fill_next;
    scd_straps_t cap_reg;
    scd_straps_t cap_next;
    logic        soft_recap_reg;
    logic        soft_recap_next;
    logic        bus_wr;
    assign bus_wr = psel && penable && pwrite;

    always_comb begin
        state_next = state_reg;
        fill_next = fill_reg;
        cap_next = cap_reg;
        soft_recap_next = 1'b0;
        unique case (state_reg)
            SCD_WAIT: begin
                // re-fill on every entry so a stale synchroniser word is never taken
                fill_next = fill_reg + 2'h1;
                if (fill_reg == 2'h2) begin
                    cap_next = sync2_reg;
                    state_next = SCD_HELD;
                end
            end
            SCD_HELD: begin
                // later switch changes are ignored unless software asks
                if (soft_recap_reg) begin
                    state_next = SCD_WAIT;
                    fill_next = 2'h0;
                end
            end
        endcase
        if (bus_wr && paddr == SCD_CTRL_OFS && pwdata[0]) begin
            soft_recap_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SCD_WAIT;
            fill_reg <= 2'h0;
            soft_recap_reg <= 1'b0;
            cap_reg.spare <= 1'b0;
            cap_reg.split_clock_domain_strap <= 1'b0;
            cap_reg.operating_mode_strap <= SCD_MODE_RST;
            cap_reg.root_facing_port_strap <= SCD_ROOT_RST;
            cap_reg.isolated_port_strap <= SCD_ISO_RST;
            cap_reg.lane_width_config_strap <= SCD_LANE_RST;
            cap_reg.slot_hotplug_select <= 1'b0;
            cap_reg.retention_latch_sense_n <= 1'b0;
            cap_reg.pll_bypass <= 1'b1;
            cap_reg.loop_bandwidth_select <= 1'b1;
            cap_reg.addr_low <= SCD_ADDR_RST;
        end else begin
            state_reg <= state_next;
            fill_reg <= fill_next;
            soft_recap_reg <= soft_recap_next;
            cap_reg <= cap_next;
        end
    end

    // ==========================================================
    // decode; pin levels are taken as is since ON already reads 0
    // codes without a table entry fall back to four x2 ports
    function automatic scd_lanes_t lane_decode(input logic [3:0] code);
        unique case (code)
            4'h2:    lane_decode = {2'h3, 2'h3, 2'h0, 2'h0, 2'h0};
            4'h3:    lane_decode = {2'h3, 2'h2, 2'h2, 2'h0, 2'h0};
            4'h4:    lane_decode = {2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
            4'h5:    lane_decode = {2'h3, 2'h1, 2'h1, 2'h2, 2'h0};
            4'h6:    lane_decode = {2'h3, 2'h1, 2'h2, 2'h1, 2'h0};
            4'h8:    lane_decode = {2'h3, 2'h1, 2'h1, 2'h1, 2'h1};
            4'h9:    lane_decode = {2'h2, 2'h2, 2'h2, 2'h1, 2'h1};
            default: lane_decode = {2'h2, 2'h2, 2'h2, 2'h2, 2'h0};
        endcase
    endfunction

    logic root_bad;
    logic iso_bad;
    logic mode_bad;
    logic non_transparent_mode;
    assign root_bad = cap_reg.root_facing_port_strap > SCD_PORT_MAX;
    assign iso_bad = cap_reg.isolated_port_strap > SCD_PORT_MAX;
    assign mode_bad = cap_reg.operating_mode_strap == SCD_MODE_RSVD;
    assign non_transparent_mode = cap_reg.operating_mode_strap == SCD_MODE_ADAPT
                  || cap_reg.operating_mode_strap == SCD_MODE_DUAL;

    // outputs registered from the captured word, straps_valid from the capture state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            split_clock_domain <= 1'b0;
            operating_mode <= SCD_MODE_RST;
            non_transparent <= 1'b0;
            root_facing_port <= 3'h0;
            isolated_port <= 3'h1;
            isolated_port_valid <= 1'b0;
            lane_widths <= '0;
            slot_hotplug_enable <= 1'b0;
            retention_latch_open <= 1'b0;
            pll_bypass <= 1'b1;
            loop_bw_1mhz <= 1'b1;
            mgmt_slave_addr <= SCD_ADDR_BASE | 7'h07;
            spare_input <= 1'b0;
            config_error <= 1'b0;
            straps_valid <= 1'b0;
        end else begin
            split_clock_domain <= cap_reg.split_clock_domain_strap;
            operating_mode <= cap_reg.operating_mode_strap;
            non_transparent <= non_transparent_mode;
            root_facing_port <= cap_reg.root_facing_port_strap[2:0];
            isolated_port <= cap_reg.isolated_port_strap[2:0];
            isolated_port_valid <= non_transparent_mode && !iso_bad;
            lane_widths <= lane_decode(cap_reg.lane_width_config_strap);
            slot_hotplug_enable <= cap_reg.slot_hotplug_select;
            retention_latch_open <= cap_reg.retention_latch_sense_n;
            pll_bypass <= cap_reg.pll_bypass;
            loop_bw_1mhz <= cap_reg.loop_bandwidth_select;
            mgmt_slave_addr <= SCD_ADDR_BASE | {4'h0, cap_reg.addr_low};
            spare_input <= cap_reg.spare;
            config_error <= mode_bad || root_bad || iso_bad;
            straps_valid <= state_reg == SCD_HELD;
        end
    end

    // ==========================================================
    // apb slave: zero wait states, unmapped reads zero with error
    // a registered answer costs no wait state since setup always precedes access
    logic [31:0] prdata_next;
    logic        pslverr_next;
    logic        map_hit;
    always_comb begin
        prdata_next = 32'h0000_0000;
        map_hit = 1'b1;
        unique case (paddr)
            SCD_RAW_OFS:    prdata_next = {9'h000, cap_reg};
            SCD_DECODE_OFS: prdata_next = {13'h0000, straps_valid, config_error,
                                           mgmt_slave_addr, isolated_port_valid,
                                           isolated_port, root_facing_port,
                                           non_transparent, operating_mode};
            SCD_LANES_OFS:  prdata_next = {22'h000000, lane_widths};
            SCD_CTRL_OFS:   prdata_next = 32'h0000_0000;
            default:        map_hit = 1'b0;
        endcase
        // error is judged in setup so that it stands together with pready
        pslverr_next = psel && !penable && !map_hit;
        if (!(psel && !penable)) begin
            prdata_next = prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            prdata <= prdata_next;
            pslverr <= pslverr_next;
            pready <= psel && !penable;
        end
    end

    // ==========================================================
    // checks
    hold_after_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == SCD_HELD && !soft_recap_reg) |=> $stable(cap_reg))
        else $error("captured straps changed while held");
    error_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cap_reg.operating_mode_strap == 2'h0) |=> config_error)
        else $error("reserved mode not flagged");
    addr_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> mgmt_slave_addr == (SCD_ADDR_BASE | {4'h0, $past(cap_reg.addr_low)}))
        else $error("slave address wrong");
    default_lanes_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cap_reg.lane_width_config_strap == 4'h8) |=> lane_widths == 10'h355)
        else $error("default lane config wrong");
    transparent_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cap_reg.operating_mode_strap == 2'h3) |=> !non_transparent
            && !isolated_port_valid)
        else $error("transparent mode shows isolated port");
    hotplug_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> slot_hotplug_enable == $past(cap_reg.slot_hotplug_select)
            && retention_latch_open == $past(cap_reg.retention_latch_sense_n))
        else $error("hotplug controls wrong");
    clock_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> pll_bypass == $past(cap_reg.pll_bypass)
            && loop_bw_1mhz == $past(cap_reg.loop_bandwidth_select)
            && split_clock_domain == $past(cap_reg.split_clock_domain_strap))
        else $error("clock controls wrong");
    spare_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> spare_input == $past(cap_reg.spare))
        else $error("spare input wrong");
    capture_time_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == SCD_WAIT && fill_reg == 2'h0) |-> ##[1:3] state_reg == SCD_HELD)
        else $error("capture took too long");

    // decoded fields and errors follow the captured word one edge later
    root_port_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> root_facing_port == $past(cap_reg.root_facing_port_strap[2:0]))
        else $error("root port wrong");
    iso_port_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> isolated_port == $past(cap_reg.isolated_port_strap[2:0]))
        else $error("isolated port wrong");
    iso_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cap_reg.isolated_port_strap > SCD_PORT_MAX) |=> !isolated_port_valid
            && config_error)
        else $error("reserved isolated port accepted");
    root_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cap_reg.root_facing_port_strap > SCD_PORT_MAX) |=> config_error)
        else $error("reserved root port not flagged");
    mode_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> operating_mode == $past(cap_reg.operating_mode_strap))
        else $error("operating mode wrong");
    bridge_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cap_reg.operating_mode_strap inside {2'h1, 2'h2}) |=> non_transparent)
        else $error("bridge mode not shown");
    wide_lanes_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cap_reg.lane_width_config_strap == 4'h9) |=> lane_widths == 10'h2A5)
        else $error("lane config nine wrong");
    other_lanes_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cap_reg.lane_width_config_strap inside {4'h0, 4'h1, 4'h7, [4'hA:4'hF]})
            |=> lane_widths == 10'h2A8)
        else $error("fallback lane config wrong");
    recap_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == SCD_HELD && soft_recap_reg) |=> state_reg == SCD_WAIT
            && fill_reg == 2'h0)
        else $error("re-capture did not restart");
    valid_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> straps_valid == ($past(state_reg) == SCD_HELD))
        else $error("valid flag wrong");

    // apb answer timing
    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready)
        else $error("setup not answered");
    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held too long");
    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr > SCD_CTRL_OFS) |=> pslverr && pready)
        else $error("unmapped access not refused");

    // main scenarios
    cover_held_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == SCD_HELD);
    cover_err_c: cover property (@(posedge pclk) disable iff (!presetn) config_error);
    cover_bridge_c: cover property (@(posedge pclk) disable iff (!presetn)
        non_transparent && isolated_port_valid);
    cover_recap_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == SCD_HELD && soft_recap_reg);
    cover_lanes_c: cover property (@(posedge pclk) disable iff (!presetn)
        lane_widths == 10'h2A5);
endmodule

// ===== scd_switch_bank.sv
// Purpose: board switch contacts that feed the strap pins
// Assumes: lever_on bit set means that lever sits in its ON position
// Notes:   contacts are static levels, so nothing is ever released
`timescale 1ns/1ps
module scd_switch_bank
    import scd_pkg::*;
(
    input  wire scd_straps_t lever_on,
    output scd_straps_t      strap_pins
);
    // ==========================================================
    // an ON lever shorts its contact to ground, OFF leaves the pull-up
    assign strap_pins = ~lever_on;
endmodule

// ===== strap_configuration_decoder_tb.sv
// Purpose: self-checking bench for the strap decoder
// Assumes: captures are forced by reset or by the re-capture control bit
// Notes:   lane, decode and raw views are compared against hand-built tables
`timescale 1ns/1ps
module strap_configuration_decoder_tb
    import scd_pkg::*;
;
    // ==========================================================
    // contact levels at the documented default lever positions
    localparam scd_straps_t DEF = 23'h180C1F;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    scd_straps_t lever_on, strap_pins, v;
    logic        split_clock_domain, non_transparent, isolated_port_valid, straps_valid;
    logic        slot_hotplug_enable, retention_latch_open, pll_bypass, loop_bw_1mhz;
    logic        spare_input, config_error;
    logic [1:0]  operating_mode;
    logic [2:0]  root_facing_port, isolated_port;
    logic [6:0]  mgmt_slave_addr;
    scd_lanes_t  lane_widths;
    logic [4:0]  i;
    int          failures = 0;
    int          comparisons = 0;

    scd_switch_bank scd_switch_bank_i (.lever_on(lever_on), .strap_pins(strap_pins));
    scd_decoder scd_decoder_i (.pclk(pclk), .presetn(presetn), .strap_pins(strap_pins),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .split_clock_domain(split_clock_domain), .operating_mode(operating_mode),
        .non_transparent(non_transparent), .root_facing_port(root_facing_port),
        .isolated_port(isolated_port), .isolated_port_valid(isolated_port_valid),
        .lane_widths(lane_widths), .slot_hotplug_enable(slot_hotplug_enable),
        .retention_latch_open(retention_latch_open), .pll_bypass(pll_bypass),
        .loop_bw_1mhz(loop_bw_1mhz), .mgmt_slave_addr(mgmt_slave_addr),
        .spare_input(spare_input), .config_error(config_error), .straps_valid(straps_valid));

    // ==========================================================
    // clock, 4 ns period
    always #2 pclk = ~pclk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer, entered just after a rising edge; an idle cycle follows
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic exp_err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        check("pready", pready, 1'b1);
        if (!wr) check("prdata", prdata, exp);
        check("pslverr", pslverr, exp_err);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // reset with the levers set, then wait for the capture to finish
    task automatic recapture(input scd_straps_t on, input int hold);
        int n;
        n = 0;
        lever_on <= on;
        presetn <= 1'b0;
        repeat (hold) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        while (straps_valid !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        check("straps_valid", straps_valid, 1'b1);
    endtask

    // 2-bit width codes per port, port 0 in the top pair
    function automatic scd_lanes_t lanes_of(input logic [3:0] c);
        case (c)
            4'h2:    return 10'h3C0;
            4'h3:    return 10'h3A0;
            4'h4:    return 10'h394;
            4'h5:    return 10'h358;
            4'h6:    return 10'h364;
            4'h8:    return 10'h355;
            4'h9:    return 10'h2A5;
            default: return 10'h2A8;
        endcase
    endfunction

    // compare every decoded output with contact levels c
    task automatic check_outputs(input scd_straps_t c);
        logic bridged, err;
        bridged = (c.operating_mode_strap == 2'h1) || (c.operating_mode_strap == 2'h2);
        err = (c.operating_mode_strap == 2'h0) || (c.root_facing_port_strap > 4'h4)
            || (c.isolated_port_strap > 4'h4);
        check("split", split_clock_domain, c.split_clock_domain_strap);
        check("mode", operating_mode, c.operating_mode_strap);
        check("non_transparent", non_transparent, bridged);
        check("root", root_facing_port, c.root_facing_port_strap[2:0]);
        check("iso", isolated_port, c.isolated_port_strap[2:0]);
        check("iso_valid", isolated_port_valid, bridged && c.isolated_port_strap <= 4'h4);
        check("lanes", lane_widths, lanes_of(c.lane_width_config_strap));
        check("hotplug", slot_hotplug_enable, c.slot_hotplug_select);
        check("latch", retention_latch_open, c.retention_latch_sense_n);
        check("bypass", pll_bypass, c.pll_bypass);
        check("bw", loop_bw_1mhz, c.loop_bandwidth_select);
        check("addr", mgmt_slave_addr, 7'h70 | c.addr_low);
        check("spare", spare_input, c.spare);
        check("cfg_err", config_error, err);
    endtask

    task automatic finish_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        finish_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        lever_on = ~DEF;
        recapture(~DEF, 10);
        check_outputs(DEF);
        $display("test defaults done");
        // sweep codes; iso mixes legal and reserved against each mode
        for (i = 5'h0; i < 5'h10; i++) begin
            v = DEF;
            v.spare = i[3];
            v.split_clock_domain_strap = i[0];
            v.operating_mode_strap = i[1:0];
            v.root_facing_port_strap = i[3:0];
            v.isolated_port_strap = i[3:0] ^ 4'h3;
            v.lane_width_config_strap = i[3:0];
            v.slot_hotplug_select = i[1];
            v.retention_latch_sense_n = i[2];
            v.pll_bypass = ~i[0];
            v.loop_bandwidth_select = i[2];
            v.addr_low = i[2:0];
            recapture(~v, 2);
            check_outputs(v);
            apb(1'b0, SCD_RAW_OFS, 32'h0, 32'(v), 1'b0);
            apb(1'b0, SCD_LANES_OFS, 32'h0, 32'(lanes_of(i[3:0])), 1'b0);
        end
        $display("test code sweep done");
        // later lever moves must not reach the outputs
        recapture(~DEF, 2);
        lever_on <= DEF;
        repeat (10) @(posedge pclk);
        check_outputs(DEF);
        apb(1'b0, SCD_DECODE_OFS, 32'h0,
            {13'h0000, 1'b1, 1'b0, 7'h77, 1'b0, 3'h1, 3'h0, 1'b0, 2'h3}, 1'b0);
        apb(1'b1, SCD_RAW_OFS, 32'h007F_FFFF, 32'h0, 1'b0);
        apb(1'b0, SCD_RAW_OFS, 32'h0, 32'(DEF), 1'b0);
        apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
        apb(1'b1, SCD_CTRL_OFS, 32'h1, 32'h0, 1'b0);
        repeat (10) @(posedge pclk);
        check_outputs(~DEF);
        apb(1'b0, SCD_CTRL_OFS, 32'h0, 32'h0, 1'b0);
        $display("test hold and re-capture done");
        finish_test();
    end
endmodule
